/* File: core/qd_pkg.sv */
// Shared constants and types for the quad DAC two-wire command port
package qd_pkg;
  // Slave address: fixed upper bits, strapped lower two
  localparam logic [4:0] ADDR_FIXED = 5'h03;
  // Command codes (upper nibble of the command byte)
  localparam logic [3:0] CMD_WR_IN  = 4'h1;
  localparam logic [3:0] CMD_UPD    = 4'h2;
  localparam logic [3:0] CMD_WR_UPD = 4'h3;
  localparam logic [3:0] CMD_PWR    = 4'h4;
  localparam logic [3:0] CMD_MASK   = 4'h5;
  localparam logic [3:0] CMD_SWRST  = 4'h6;
  // Channel count and code width
  localparam int NUM_CH = 4;
  localparam int CODE_W = 16;
  // Reset values of the device registers
  localparam logic [15:0] RST_CODE = 16'h0000;
  localparam logic [7:0]  RST_PWR  = 8'h00;
  localparam logic [3:0]  RST_MASK = 4'h0;
  // Controller register offsets (byte addresses)
  localparam logic [7:0] HR_SLAVE = 8'h00;
  localparam logic [7:0] HR_WORD  = 8'h04;
  localparam logic [7:0] HR_GO    = 8'h08;
  localparam logic [7:0] HR_STAT  = 8'h0c;
  localparam logic [7:0] HR_RDATA = 8'h10;
  // Field positions in the controller registers
  localparam int GO_WR   = 0;
  localparam int GO_RD   = 1;
  localparam int GO_CNT  = 4;
  localparam int ST_DONE = 0;
  localparam int ST_NACK = 1;
  localparam int ST_BUSY = 2;
  // Link timing: system clock and bus clock period
  localparam int CLK_NS        = 20;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
  // Device and controller states
  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_ACK_ADDR, D_RX, D_ACK_RX, D_TX, D_MACK
  } qd_dev_st_e;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} qd_host_st_e;
endpackage

/* File: core/qd_if.sv */
// Two-wire link between the controller and the DAC command port
`timescale 1ns/1ps
`default_nettype none
interface qd_if;
  logic scl;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic sda;
  // Open-drain wire: low while any end pulls
  assign sda = ~(host_sda_oe | dev_sda_oe);
  modport host (output scl, output host_sda_oe, input sda);
  modport dev  (input scl, input sda, output dev_sda_oe);
endinterface
`default_nettype wire

/* File: core/qd_dev.sv */
// Device end: two-wire slave and channel registers of the quad DAC
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Write command loads input register; strobe-low follows
// - Update command copies input into DAC register
// - Write-and-update loads both registers, ignoring strobe
// - Address is fixed 00011 plus two straps
// - Start condition, then address byte follows
// - Matching slave acknowledges on ninth pulse
// - Nine pulses per byte; change SDA only low
// - Master ends with stop, reads with no-ack
// - Write frame: address, command, high, low bytes
// - Readback: command, repeated start, read, two bytes
// - Several channels selected reads channel A
// - Read returns input registers high byte first
// - Readback pointer wraps from D to A
// - Power command takes two mode bits each
// - Modes: normal, 1k, 100k, three-state
// - Nonzero mode field means channel powered down
// - Power-down keeps DAC registers, writes still accepted
// - Each channel holds input and DAC register
// - Word: command nibble, select nibble, data word
// - Select bits enable channels D, C, B, A
// - Data word is sixteen bits, left aligned
// - Strobe falling edge copies unmasked channels
module qd_dev (
  // Clock, reset, enable
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // Two-wire link
  qd_if.dev                             bus,
  // Pins
  input  wire logic                     load_strobe_n,
  input  wire logic                     addr_strap_hi,
  input  wire logic                     addr_strap_lo,
  // Channel state towards the analog side
  output logic [qd_pkg::NUM_CH-1:0][qd_pkg::CODE_W-1:0] dac_code,
  output logic [qd_pkg::NUM_CH-1:0][qd_pkg::CODE_W-1:0] in_code,
  output logic [2*qd_pkg::NUM_CH-1:0]   pwr_mode,
  output logic [qd_pkg::NUM_CH-1:0]     ch_off,
  output logic [qd_pkg::NUM_CH-1:0]     ld_mask
);
  import qd_pkg::*;

  typedef struct packed {
    logic [1:0]                       scl_s, sda_s, ld_s, hi_s, lo_s;
    logic                             scl_q, sda_q, ld_q;
    qd_dev_st_e                       st;
    logic [3:0]                       bitn;
    logic [7:0]                       sh;
    logic [1:0]                       bcnt;
    logic [7:0]                       cmd;
    logic [7:0]                       dhi;
    logic [1:0]                       ptr;
    logic                             rlo, mack, sda_oe;
    logic [NUM_CH-1:0][CODE_W-1:0]    inr, dac;
    logic [2*NUM_CH-1:0]              pwr;
    logic [NUM_CH-1:0]                mask, off;
  } qd_dev_s;

  qd_dev_s r;
  qd_dev_s n;

  logic       scl, sda, ld, scl_r, scl_f, start, stop, ld_fall;
  logic [6:0] own_addr;

  // First readback channel from the select nibble
  function automatic logic [1:0] rd_ch(input logic [3:0] nib);
    case (nib)
      4'h2:    rd_ch = 2'h1;
      4'h4:    rd_ch = 2'h2;
      4'h8:    rd_ch = 2'h3;
      default: rd_ch = 2'h0;
    endcase
  endfunction

  // Byte of a channel's input register, high half first
  function automatic logic [7:0] rd_byte(
    input logic [NUM_CH-1:0][CODE_W-1:0] regs,
    input logic [1:0]                    ch,
    input logic                          lo
  );
    rd_byte = lo ? regs[ch][7:0] : regs[ch][15:8];
  endfunction

  // Synchronised line levels and their events
  assign scl      = r.scl_s[1];
  assign sda      = r.sda_s[1];
  assign ld       = r.ld_s[1];
  assign scl_r    = scl & ~r.scl_q;
  assign scl_f    = ~scl & r.scl_q;
  assign start    = scl & r.scl_q & r.sda_q & ~sda;
  assign stop     = scl & r.scl_q & ~r.sda_q & sda;
  assign ld_fall  = r.ld_q & ~ld;
  assign own_addr = {ADDR_FIXED, r.hi_s[1], r.lo_s[1]};

  // Next-state logic: bus engine, command execution, strobe
  always_comb begin
    logic        go;
    logic [15:0] d;
    logic [3:0]  sel;
    logic [1:0]  np;
    go  = 1'b0;
    d   = {r.dhi, r.sh};
    sel = r.cmd[3:0];
    np  = r.ptr + 2'h1;
    n   = r;
    n.scl_s = {r.scl_s[0], bus.scl};
    n.sda_s = {r.sda_s[0], bus.sda};
    n.ld_s  = {r.ld_s[0], load_strobe_n};
    n.hi_s  = {r.hi_s[0], addr_strap_hi};
    n.lo_s  = {r.lo_s[0], addr_strap_lo};
    n.scl_q = scl;
    n.sda_q = sda;
    n.ld_q  = ld;
    if (stop) begin
      n.st     = D_IDLE;
      n.sda_oe = 1'b0;
    end else if (start) begin
      n.st     = D_ADDR;
      n.bitn   = 4'h0;
      n.bcnt   = 2'h0;
      n.sda_oe = 1'b0;
    end else begin
      case (r.st)
        D_ADDR, D_RX: begin
          if (scl_r) begin
            n.sh   = {r.sh[6:0], sda};
            n.bitn = r.bitn + 4'h1;
          end else if (scl_f && r.bitn == 4'h8) begin
            if (r.st == D_RX) begin
              n.sda_oe = 1'b1;
              n.st     = D_ACK_RX;
            end else if (r.sh[7:1] == own_addr) begin
              n.sda_oe = 1'b1;
              n.st     = D_ACK_ADDR;
            end else begin
              n.st = D_IDLE;
            end
          end
        end
        D_ACK_ADDR: begin
          if (scl_f) begin
            n.bitn   = 4'h0;
            n.sda_oe = 1'b0;
            if (r.sh[0]) begin
              n.st     = D_TX;
              n.rlo    = 1'b0;
              n.sh     = rd_byte(r.inr, r.ptr, 1'b0);
              n.sda_oe = ~n.sh[7];
            end else begin
              n.st   = D_RX;
              n.bcnt = 2'h0;
            end
          end
        end
        D_ACK_RX: begin
          if (scl_f) begin
            n.sda_oe = 1'b0;
            n.bitn   = 4'h0;
            n.st     = D_RX;
            case (r.bcnt)
              2'h0: begin
                n.cmd  = r.sh;
                n.ptr  = rd_ch(r.sh[3:0]);
                n.bcnt = 2'h1;
              end
              2'h1: begin
                n.dhi  = r.sh;
                n.bcnt = 2'h2;
              end
              default: begin
                go     = 1'b1;
                n.bcnt = 2'h0;
              end
            endcase
          end
        end
        D_TX: begin
          if (scl_f) begin
            if (r.bitn == 4'h7) begin
              n.sda_oe = 1'b0;
              n.st     = D_MACK;
            end else begin
              n.bitn   = r.bitn + 4'h1;
              n.sh     = {r.sh[6:0], 1'b0};
              n.sda_oe = ~r.sh[6];
            end
          end
        end
        D_MACK: begin
          if (scl_r) begin
            n.mack = ~sda;
          end else if (scl_f) begin
            if (r.mack) begin
              if (r.rlo) begin
                n.ptr = np;
              end
              n.rlo    = ~r.rlo;
              n.sh     = rd_byte(r.inr, r.rlo ? np : r.ptr, ~r.rlo);
              n.sda_oe = ~n.sh[7];
              n.bitn   = 4'h0;
              n.st     = D_TX;
            end else begin
              n.st = D_IDLE;
            end
          end
        end
        default: ;
      endcase
    end
    // Execute a complete word; writes land even when powered down
    if (go) begin
      case (r.cmd[7:4])
        CMD_WR_IN, CMD_UPD, CMD_WR_UPD: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (sel[i]) begin
              if (r.cmd[7:4] != CMD_UPD) begin
                n.inr[i] = d;
              end
              if (r.cmd[7:4] == CMD_WR_UPD) begin
                n.dac[i] = d;
              end
              if (r.cmd[7:4] == CMD_UPD) begin
                n.dac[i] = r.inr[i];
              end
            end
          end
        end
        CMD_PWR:  n.pwr  = d[7:0];
        CMD_MASK: n.mask = d[3:0];
        CMD_SWRST: begin
          n.inr  = {NUM_CH{RST_CODE}};
          n.dac  = {NUM_CH{RST_CODE}};
          n.pwr  = RST_PWR;
          n.mask = RST_MASK;
        end
        default: ;
      endcase
    end
    // Strobe low or falling: unmasked DAC registers take input
    for (int i = 0; i < NUM_CH; i++) begin
      if (!r.mask[i] && (ld_fall || !ld)) begin
        n.dac[i] = n.inr[i];
      end
      n.off[i] = |n.pwr[2*i +: 2];
    end
  end

  // State register; line samples reset to idle high, no false edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      {r.scl_s, r.sda_s, r.ld_s} <= 6'h3f;
      {r.scl_q, r.sda_q, r.ld_q} <= 3'h7;
    end else if (ce) begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign bus.dev_sda_oe = r.sda_oe;
  assign dac_code       = r.dac;
  assign in_code        = r.inr;
  assign pwr_mode       = r.pwr;
  assign ch_off         = r.off;
  assign ld_mask        = r.mask;
endmodule
`default_nettype wire

/* File: core/qd_host.sv */
// Controller end: two-wire master driven from a register port
`timescale 1ns/1ps
`default_nettype none
module qd_host #(
  parameter int QTR = qd_pkg::QTR_CYC
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Two-wire link
  qd_if.host               bus,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata
);
  import qd_pkg::*;

  // Quarter counter is eight bits wide; device needs sync margin
  if (QTR < 8 || QTR > 256) begin : g_chk
    $error("qd_host: QTR out of range");
  end

  typedef struct packed {
    logic [1:0]  sda_s;
    qd_host_st_e st;
    logic [1:0]  q;
    logic [7:0]  qc;
    logic [3:0]  bitn;
    logic [2:0]  bidx;
    logic        rd_mode;
    logic        rx;
    logic        ack;
    logic        rhi;
    logic [5:0]  rem;
    logic [7:0]  sh;
    logic [6:0]  slave;
    logic [23:0] word;
    logic [15:0] rword;
    logic        busy;
    logic        done;
    logic        nack;
    logic        scl;
    logic        sda_oe;
    logic [31:0] rdo;
  } qd_host_s;

  qd_host_s r;
  qd_host_s n;

  logic sda;
  logic tick;

  // Byte to send at each step of a frame
  function automatic logic [7:0] tx_byte(input qd_host_s s);
    case (s.bidx)
      3'h0:    tx_byte = {s.slave, 1'b0};
      3'h1:    tx_byte = s.word[23:16];
      3'h2:    tx_byte = s.rd_mode ? {s.slave, 1'b1} : s.word[15:8];
      default: tx_byte = s.word[7:0];
    endcase
  endfunction

  assign sda  = r.sda_s[1];
  assign tick = (r.qc == 8'(QTR - 1));

  // Next-state logic: register port, then bit engine
  always_comb begin
    logic [3:0] cnt;
    cnt = wdata[GO_CNT +: 4];
    n   = r;
    n.sda_s = {r.sda_s[0], bus.sda};
    n.rdo   = 32'h0000_0000;
    if (rd) begin
      case (addr)
        HR_SLAVE: n.rdo = {25'h0, r.slave};
        HR_WORD:  n.rdo = {8'h00, r.word};
        HR_STAT:  n.rdo = {29'h0, r.busy, r.nack, r.done};
        HR_RDATA: n.rdo = {16'h0000, r.rword};
        default:  n.rdo = 32'h0000_0000;
      endcase
    end
    if (wr && addr == HR_STAT) begin
      n.done = r.done & ~wdata[ST_DONE];
      n.nack = r.nack & ~wdata[ST_NACK];
    end
    if (wr && !r.busy) begin
      if (addr == HR_SLAVE) n.slave = wdata[6:0];
      if (addr == HR_WORD)  n.word  = wdata[23:0];
      if (addr == HR_GO && (wdata[GO_WR] || wdata[GO_RD])) begin
        n.busy    = 1'b1;
        n.done    = 1'b0;
        n.st      = H_START;
        n.q       = 2'h0;
        n.qc      = 8'h00;
        n.sda_oe  = 1'b0;
        n.bidx    = 3'h0;
        n.rx      = 1'b0;
        n.rhi     = 1'b0;
        n.rd_mode = ~wdata[GO_WR];
        n.rem     = {1'b0, (cnt == 4'h0) ? 4'h1 : cnt, 1'b0};
      end
    end
    // Quarter phases: low, high, high (sample at end), low
    if (r.st != H_IDLE) begin
      n.qc = tick ? 8'h00 : r.qc + 8'h01;
      if (tick) begin
        n.q = r.q + 2'h1;
        case (r.q)
          2'h0: n.scl = 1'b1;
          2'h1: begin
            if (r.st == H_START) n.sda_oe = 1'b1;
            if (r.st == H_STOP)  n.sda_oe = 1'b0;
          end
          2'h2: begin
            if (r.st != H_STOP) n.scl = 1'b0;
            if (r.st == H_BIT && r.bitn != 4'h8 && r.rx) begin
              n.sh = {r.sh[6:0], sda};
            end
            if (r.st == H_BIT && r.bitn == 4'h8 && !r.rx) begin
              n.ack = ~sda;
            end
          end
          default: begin
            if (r.st == H_STOP) begin
              n.st   = H_IDLE;
              n.busy = 1'b0;
              n.done = 1'b1;
            end else if (r.st == H_START) begin
              n.st     = H_BIT;
              n.bitn   = 4'h0;
              n.sh     = tx_byte(r);
              n.sda_oe = ~n.sh[7];
            end else if (r.bitn != 4'h8) begin
              n.bitn = r.bitn + 4'h1;
              if (!r.rx) n.sh = {r.sh[6:0], 1'b0};
              if (r.bitn == 4'h7) begin
                n.sda_oe = r.rx && r.rem != 6'h01;
              end else begin
                n.sda_oe = !r.rx && !n.sh[7];
              end
            end else if (!r.rx && !r.ack) begin
              n.nack   = 1'b1;
              n.st     = H_STOP;
              n.sda_oe = 1'b1;
            end else if (r.rx) begin
              if (r.rhi) n.rword[7:0]  = r.sh;
              else       n.rword[15:8] = r.sh;
              n.rhi = ~r.rhi;
              n.rem = r.rem - 6'h01;
              n.bitn   = 4'h0;
              n.sda_oe = 1'b0;
              if (r.rem == 6'h01) begin
                n.st     = H_STOP;
                n.sda_oe = 1'b1;
              end
            end else begin
              n.bidx   = r.bidx + 3'h1;
              n.bitn   = 4'h0;
              n.sda_oe = 1'b0;
              if (!r.rd_mode && r.bidx == 3'h3) begin
                n.st     = H_STOP;
                n.sda_oe = 1'b1;
              end else if (r.rd_mode && r.bidx == 3'h1) begin
                n.st = H_START;
              end else if (r.rd_mode && r.bidx == 3'h2) begin
                n.rx = 1'b1;
              end else begin
                n.sh     = tx_byte(n);
                n.sda_oe = ~n.sh[7];
              end
            end
          end
        endcase
      end
    end
  end

  // State register; the clock line idles high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r     <= '0;
      r.scl <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign bus.scl         = r.scl;
  assign bus.host_sda_oe = r.sda_oe;
  assign rdata           = r.rdo;
endmodule
`default_nettype wire

/* File: sim/qd_link_monitor.sv */
// Protocol checker on the two-wire link between controller and device
`timescale 1ns/1ps
`default_nettype none
module qd_link_monitor #(
  parameter logic [6:0] SLAVE = 7'h0e
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  logic       scl_q, sda_q, in_frame, rw, hit, nak;
  logic [3:0] cnt;
  logic [2:0] byte_n;
  logic [7:0] sh;
  // Frame, bit position and address byte tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {scl_q, sda_q, in_frame, rw, hit, nak} <= 6'h30;
      cnt <= 4'h0;
      byte_n <= 3'h0;
      sh <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        in_frame <= 1'b1;
        nak <= 1'b0;
        cnt <= 4'h0;
        byte_n <= 3'h0;
      end else if (scl && scl_q && !sda_q && sda) begin
        in_frame <= 1'b0;
      end else if (scl && !scl_q) begin
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        if (cnt < 4'h8) sh <= {sh[6:0], sda};
        if (cnt == 4'h8 && byte_n != 3'h7) byte_n <= byte_n + 3'h1;
        if (cnt == 4'h7 && byte_n == 3'h0) rw <= sda;
        if (cnt == 4'h8 && byte_n != 3'h0 && rw) nak <= sda;
        if (cnt == 4'h8 && byte_n == 3'h0) hit <= (sh[7:1] == SLAVE);
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Link assertions
  a_dev_sda_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved SDA while SCL high");
  a_clock_in_frame: assert property ($fell(scl) |-> in_frame)
    else $error("SCL pulsed outside a frame");
  a_addr_ack_match: assert property ($rose(scl) && cnt == 4'h8 &&
    byte_n == 3'h0 |-> dev_sda_oe == (sh[7:1] == SLAVE))
    else $error("address acknowledge wrong");
  a_write_byte_ack: assert property ($rose(scl) && cnt == 4'h8 &&
    byte_n != 3'h0 && !rw && hit |-> dev_sda_oe)
    else $error("write byte not acknowledged");
  a_read_dev_release: assert property ($rose(scl) && cnt == 4'h8 &&
    byte_n != 3'h0 && rw |-> !dev_sda_oe)
    else $error("device held SDA on master acknowledge");
  a_read_host_quiet: assert property ($rose(scl) && cnt < 4'h8 &&
    byte_n != 3'h0 && rw && !nak |-> !host_sda_oe)
    else $error("controller drove SDA during read data");
  a_sda_only_framing: assert property (scl && $past(scl) &&
    $changed(sda) |-> cnt <= 4'h1)
    else $error("SDA changed with SCL high inside a byte");
  a_ack_release_bound: assert property ($fell(scl) && cnt == 4'h0 &&
    !rw && dev_sda_oe |-> ##[1:5] !dev_sda_oe)
    else $error("acknowledge not released in time");
endmodule
`default_nettype wire

/* File: sim/quad_dac_i2c_command_port_tb.sv */
// Self-checking bench joining controller and device over the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) \
  begin \
    compares++; \
    if ((act) !== (exp)) begin \
      failures++; \
      $display("[ERR] %0t got %0h want %0h", $time, act, exp); \
    end \
  end
module quad_dac_i2c_command_port_tb import qd_pkg::*; ;
  localparam logic [6:0] SLV = {ADDR_FIXED, 2'b10};
  logic                          clk, rst, wr, rd, load_strobe_n;
  logic [7:0]                    addr, pwr_mode;
  logic [31:0]                   wdata, rdata;
  logic [NUM_CH-1:0][CODE_W-1:0] dac_code, in_code;
  logic [3:0]                    ch_off, ld_mask;
  int                            failures, compares, cyc;
  // Link and both ends
  qd_if u_qd_if ();
  qd_host #(.QTR(8)) u_qd_host (.clk(clk), .rst(rst), .ce(1'b1),
    .bus(u_qd_if), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  qd_dev u_qd_dev (.clk(clk), .rst(rst), .ce(1'b1), .bus(u_qd_if),
    .load_strobe_n(load_strobe_n), .addr_strap_hi(1'b1),
    .addr_strap_lo(1'b0), .dac_code(dac_code), .in_code(in_code),
    .pwr_mode(pwr_mode), .ch_off(ch_off), .ld_mask(ld_mask));
  qd_link_monitor #(.SLAVE(SLV)) u_qd_link_monitor (.clk(clk),
    .rst(rst), .scl(u_qd_if.scl), .sda(u_qd_if.sda),
    .host_sda_oe(u_qd_if.host_sda_oe), .dev_sda_oe(u_qd_if.dev_sda_oe));
  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Register port cycles
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // One frame, polled to completion, flags cleared after
  task automatic xfer(input logic [6:0] s, input logic [23:0] w,
                      input logic [7:0] go, output logic [1:0] res);
    logic [31:0] st;
    int          n;
    reg_wr(HR_SLAVE, {25'h0, s});
    reg_wr(HR_WORD, {8'h00, w});
    reg_wr(HR_GO, {24'h0, go});
    n = 0;
    st = 32'h0;
    while ((st[ST_DONE] !== 1'b1 || st[ST_BUSY] !== 1'b0) && n < 4000) begin
      reg_rd(HR_STAT, st);
      n++;
    end
    if (n >= 4000) failures++;
    res = {st[ST_NACK], st[ST_DONE]};
    reg_wr(HR_STAT, 32'h3);
  endtask
  task automatic send(input logic [23:0] w);
    logic [1:0] res;
    xfer(SLV, w, 8'h01, res);
    `CHK(res, 2'b01);
  endtask
  // Scenarios
  task automatic t_wr_upd();
    send(24'h3f1234);
    for (int c = 0; c < NUM_CH; c++) begin
      `CHK(in_code[c], 16'h1234);
      `CHK(dac_code[c], 16'h1234);
    end
  endtask
  task automatic t_two_level();
    send(24'h12abcd);
    `CHK(in_code[1], 16'habcd);
    `CHK(dac_code[1], 16'h1234);
    `CHK(in_code[0], 16'h1234);
    send(24'h220000);
    `CHK(dac_code[1], 16'habcd);
    `CHK(in_code[1], 16'habcd);
    `CHK(dac_code[0], 16'h1234);
  endtask
  task automatic t_strobe();
    send(24'h500001);
    `CHK(ld_mask, 4'h1);
    send(24'h15a5c3);
    `CHK(dac_code[2], 16'h1234);
    @(posedge clk);
    load_strobe_n <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK(dac_code[2], 16'ha5c3);
    `CHK(dac_code[0], 16'h1234);
    send(24'h14beef);
    `CHK(dac_code[2], 16'hbeef);
    @(posedge clk);
    load_strobe_n <= 1'b1;
    send(24'h500000);
    `CHK(ld_mask, 4'h0);
  endtask
  task automatic t_power();
    send(24'h4fabe4);
    `CHK(pwr_mode, 8'he4);
    `CHK(ch_off, 4'b1110);
    `CHK(dac_code[3], 16'h1234);
    send(24'h3e789a);
    `CHK(dac_code[3], 16'h789a);
    send(24'h400000);
    `CHK(ch_off, 4'h0);
  endtask
  task automatic t_no_effect();
    logic [NUM_CH-1:0][CODE_W-1:0] s_in, s_dac;
    logic [3:0]                    codes [4] = '{4'h0, 4'h7, 4'h8, 4'hf};
    logic [1:0]                    res;
    s_in = in_code;
    s_dac = dac_code;
    for (int i = 0; i < 4; i++) send({codes[i], 20'hfffff});
    `CHK(in_code, s_in);
    `CHK(dac_code, s_dac);
    `CHK({pwr_mode, ld_mask}, 12'h000);
    xfer({ADDR_FIXED, 2'b01}, 24'h3f0000, 8'h01, res);
    `CHK(res, 2'b11);
    `CHK(dac_code, s_dac);
  endtask
  task automatic t_readback();
    logic [23:0] w [3] = '{24'h080000, 24'h0f0000, 24'h010000};
    logic [7:0]  g [3] = '{8'h22, 8'h12, 8'h22};
    logic [15:0] e [3] = '{16'ha5c3, 16'ha5c3, 16'h789a};
    logic [31:0] d;
    logic [1:0]  res;
    for (int i = 0; i < 3; i++) begin
      xfer(SLV, w[i], g[i], res);
      `CHK(res, 2'b01);
      reg_rd(HR_RDATA, d);
      `CHK(d[15:0], e[i]);
    end
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    load_strobe_n = 1'b1;
    failures = 0;
    compares = 0;
    cyc = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_wr_upd();
    t_two_level();
    t_strobe();
    t_power();
    t_no_effect();
    t_readback();
    tally_and_finish();
  end
endmodule
`default_nettype wire
